// >>> logic/atx_ctrl_map.vh
// Register offsets, field positions, reset values and codes of the transmitter control bank
`ifndef ATX_CTRL_MAP_VH
`define ATX_CTRL_MAP_VH

// Register offsets (byte addresses on the control port)
`define ATX_OFS_RSVD0 7'h00
`define ATX_OFS_CTL1 7'h01
`define ATX_OFS_MONO 7'h02
`define ATX_OFS_FLOW 7'h03
`define ATX_OFS_CLK 7'h04
`define ATX_OFS_FMT 7'h05
`define ATX_OFS_RSVD6 7'h06
`define ATX_OFS_STAT1 7'h07
`define ATX_OFS_STAT2 7'h08
`define ATX_OFS_MASK1 7'h09
`define ATX_OFS_MODE1H 7'h0a
`define ATX_OFS_MODE1L 7'h0b
`define ATX_OFS_MASK2 7'h0c
`define ATX_OFS_MODE2H 7'h0d
`define ATX_OFS_MODE2L 7'h0e
`define ATX_OFS_CSBUF 7'h12
`define ATX_OFS_UBUF 7'h13
`define ATX_OFS_BUF 7'h20
`define ATX_OFS_ID 7'h7f

// Writable bits of each register
`define ATX_WM_CTL1 8'h57
`define ATX_WM_MONO 8'h07
`define ATX_WM_FLOW 8'h60
`define ATX_WM_CLK 8'h70
`define ATX_WM_FMT 8'hff
`define ATX_WM_IRQ1 8'h82
`define ATX_WM_IRQ2 8'h04
`define ATX_WM_CSBUF 8'h27
`define ATX_WM_UBUF 8'h1d

// Reset value shared by all registers except the identity register
`define ATX_RST_VAL 8'h00

// Field positions
`define ATX_PTR_AUTO_INCREMENT_ENABLE 7
`define ATX_C1_VALID 6
`define ATX_C1_MUTE 4
`define ATX_C1_STY_HI 2
`define ATX_C1_STY_LO 1
`define ATX_C1_BLKDIR 0
`define ATX_M_ENABLE 2
`define ATX_M_STATUS 1
`define ATX_M_CHAN 0
`define ATX_F_DRVOFF 6
`define ATX_F_BYPASS 5
`define ATX_K_RUN 6
`define ATX_K_RAT_HI 5
`define ATX_K_RAT_LO 4
`define ATX_S_MASTER 7
`define ATX_S_BCLK 6
`define ATX_S_RES_HI 5
`define ATX_S_RES_LO 4
`define ATX_S_JUST 3
`define ATX_S_DEL 2
`define ATX_S_BPOL 1
`define ATX_S_FPOL 0
`define ATX_I1_SLIP 7
`define ATX_I1_CSX 1
`define ATX_I2_UX 2

// Interrupt pin styles
`define ATX_STY_HIGH 2'h0
`define ATX_STY_LOW 2'h1
`define ATX_STY_OD 2'h2

// Interrupt source modes
`define ATX_MODE_RISE 2'h0
`define ATX_MODE_FALL 2'h1
`define ATX_MODE_LEVEL 2'h2

// Clock ratios and master bit clock rates, in multiples of Fs
`define ATX_RATIO_256 10'h100
`define ATX_RATIO_384 10'h180
`define ATX_RATIO_512 10'h200
`define ATX_BCLK_64 10'h040
`define ATX_BCLK_128 10'h080

// Word lengths for right-justified input
`define ATX_RES_24 5'h18
`define ATX_RES_20 5'h14
`define ATX_RES_16 5'h10

`endif

// >>> logic/atx_ctrl_regs.v
// Control and status register bank of the audio interface transmitter
`timescale 1ns/100ps
`default_nettype none
`include "atx_ctrl_map.vh"

// What this block does
// - Pointer: bit 7 auto-increment, bits 6:0 address
// - Validity setting drives transmitted V bit
// - Mute bit silences transmitted audio data
// - Style field: high, low, open-drain interrupt
// - Direction bit: boundary pin input or output
// - Mono enable: one channel, successive subframes
// - Status select: per-subframe or one shared set
// - Mono channel select picks left or right
// - Driver-off forces both line outputs low
// - Bypass routes receive pin to line driver
// - Run low: line off, strobes stopped, buffers refused
// - Ratio field selects 256, 384, 512 Fs
// - Master select: input port drives clocks
// - Master bit clock 64 or 128 Fs
// - Resolution field: 24, 20, 16 bits
// - Justification and left-justified MSB delay
// - Bit clock polarity picks sampling edge
// - Frame clock polarity picks high channel
// - Status sticky, read clears except live level
// - Masked status bits always read zero
// - Mask one passes source, zero blocks; reset
// - Mode pairs: rising, falling, level codes
// - Slip fires on slip, or on boundary pulse while the pin is an input
// - Status transfer source true during copy
module atx_ctrl_regs #(
	parameter [3:0] ID_CODE = 4'h9,
	parameter [3:0] REV_CODE = 4'h3,
	parameter BUF_DEPTH = 24
) (
	input wire ref_clk,
	input wire rst,
	input wire ce,
	input wire host_wr_map,
	input wire host_wr_data,
	input wire host_rd,
	input wire [7:0] host_byte,
	output reg [7:0] host_rd_data,
	output reg host_rd_valid,
	input wire source_slip_event,
	input wire status_buffer_transfer_event,
	input wire user_buffer_transfer_event,
	output reg irq_pin_out,
	output reg irq_pin_oe,
	input wire block_boundary_pin_in,
	output reg block_boundary_pin_out,
	output reg block_boundary_pin_oe,
	input wire block_start_in,
	input wire receive_input_pin,
	input wire encoded_stream_in,
	output reg line_p_out,
	output reg line_n_out,
	input wire input_bit_clock,
	input wire input_frame_clock,
	output reg sample_strobe,
	output reg channel_is_left,
	input wire [23:0] left_sample,
	input wire [23:0] right_sample,
	input wire subframe_b,
	output reg [23:0] subframe_audio,
	output reg status_from_b,
	output reg validity_bit,
	output reg datapath_run,
	output reg [9:0] mclk_ratio,
	output reg [3:0] master_bclk_div,
	output reg input_port_master,
	output reg [4:0] word_length,
	output reg input_right_justified,
	output reg input_msb_delay,
	output reg [1:0] user_bit_mode,
	output reg status_transfer_inhibit,
	output reg user_transfer_inhibit,
	output reg buffer_holds_user
);

	// Edge or level detection of one interrupt source
	function irq_hit;
		input [1:0] mode;
		input cur;
		input prev;
		begin
			case (mode)
				`ATX_MODE_RISE: irq_hit = cur & ~prev;
				`ATX_MODE_FALL: irq_hit = ~cur & prev;
				`ATX_MODE_LEVEL: irq_hit = cur;
				default: irq_hit = 1'b0;
			endcase
		end
	endfunction

	// Master-clock multiple per Fs for a ratio code
	function [9:0] ratio_of;
		input [1:0] code;
		begin
			case (code)
				2'h1: ratio_of = `ATX_RATIO_384;
				2'h2: ratio_of = `ATX_RATIO_512;
				default: ratio_of = `ATX_RATIO_256;
			endcase
		end
	endfunction

	reg [6:0] ptr_r;
	reg auto_increment_enable_r;
	reg [7:0] ctl1_r;
	reg [7:0] mono_r;
	reg [7:0] flow_r;
	reg [7:0] clk_r;
	reg [7:0] fmt_r;
	reg [7:0] mask1_r;
	reg [7:0] mode1h_r;
	reg [7:0] mode1l_r;
	reg [7:0] mask2_r;
	reg [7:0] mode2h_r;
	reg [7:0] mode2l_r;
	reg [7:0] csbuf_r;
	reg [7:0] ubuf_r;
	reg [7:0] stat1_r;
	reg [7:0] stat2_r;
	reg [7:0] stat1_nxt;
	reg [7:0] stat2_nxt;
	reg [7:0] src1_d_r;
	reg [7:0] src2_d_r;
	reg [7:0] ev1;
	reg [7:0] ev2;
	reg [7:0] rd_mux;
	reg [7:0] rd_reg_r;
	reg rd_buf_r;
	reg rd_stage_r;
	reg bclk_d_r;
	reg blk_d_r;
	reg irq_any;
	reg [9:0] ratio_val;
	reg [9:0] bclk_val;
	integer i;

	wire [3:0] pins_stable;
	wire blk_sync;
	wire rxp_sync;
	wire bclk_sync;
	wire fclk_sync;
	wire [7:0] buf_q;
	wire [6:0] buf_ofs;
	wire run;
	wire in_buf;
	wire buf_ok;
	wire data_xfer;
	wire rd_stat1;
	wire rd_stat2;
	wire blk_pulse;
	wire [7:0] src1;
	wire [7:0] src2;
	wire line_src;
	wire line_off;

	// Pins from outside the clock domain, filtered before use
	atx_pin_sync #(
		.WIDTH(4)
	) u_sync (
		.ref_clk(ref_clk),
		.rst(rst),
		.ce(ce),
		.pin_in({input_frame_clock, input_bit_clock, receive_input_pin, block_boundary_pin_in}),
		.pin_stable(pins_stable)
	);

	assign blk_sync = pins_stable[0];
	assign rxp_sync = pins_stable[1];
	assign bclk_sync = pins_stable[2];
	assign fclk_sync = pins_stable[3];

	// Decode of the addressed register and of buffer access
	assign run = clk_r[`ATX_K_RUN];
	assign buf_ofs = ptr_r - `ATX_OFS_BUF;
	assign in_buf = (ptr_r >= `ATX_OFS_BUF) && (buf_ofs < BUF_DEPTH[6:0]);
	assign buf_ok = in_buf & run;
	assign data_xfer = ~host_wr_map & (host_wr_data | host_rd);
	assign rd_stat1 = ~host_wr_map & host_rd & (ptr_r == `ATX_OFS_STAT1);
	assign rd_stat2 = ~host_wr_map & host_rd & (ptr_r == `ATX_OFS_STAT2);

	atx_side_buf #(
		.DEPTH(BUF_DEPTH),
		.AW(5)
	) u_buf (
		.ref_clk(ref_clk),
		.rst(rst),
		.ce(ce),
		.wr_en(~host_wr_map & host_wr_data & buf_ok),
		.addr(buf_ofs[4:0]),
		.wr_data(host_byte),
		.rd_data(buf_q)
	);

	// Pointer and auto-increment; a pointer write beats a data strobe in the same cycle
	always @(posedge ref_clk) begin
		if (rst) begin
			ptr_r <= 7'h00;
			auto_increment_enable_r <= 1'b0;
		end else if (ce) begin
			if (host_wr_map) begin
				auto_increment_enable_r <= host_byte[`ATX_PTR_AUTO_INCREMENT_ENABLE];
				ptr_r <= host_byte[6:0];
			end else if (data_xfer && auto_increment_enable_r) begin
				ptr_r <= ptr_r + 7'h01;
			end
		end
	end

	// Control registers; reserved, read-only and status addresses ignore writes
	always @(posedge ref_clk) begin
		if (rst) begin
			ctl1_r <= `ATX_RST_VAL;
			mono_r <= `ATX_RST_VAL;
			flow_r <= `ATX_RST_VAL;
			clk_r <= `ATX_RST_VAL;
			fmt_r <= `ATX_RST_VAL;
			mask1_r <= `ATX_RST_VAL;
			mode1h_r <= `ATX_RST_VAL;
			mode1l_r <= `ATX_RST_VAL;
			mask2_r <= `ATX_RST_VAL;
			mode2h_r <= `ATX_RST_VAL;
			mode2l_r <= `ATX_RST_VAL;
			csbuf_r <= `ATX_RST_VAL;
			ubuf_r <= `ATX_RST_VAL;
		end else if (ce && host_wr_data && !host_wr_map) begin
			case (ptr_r)
				`ATX_OFS_CTL1: ctl1_r <= host_byte & `ATX_WM_CTL1;
				`ATX_OFS_MONO: mono_r <= host_byte & `ATX_WM_MONO;
				`ATX_OFS_FLOW: flow_r <= host_byte & `ATX_WM_FLOW;
				`ATX_OFS_CLK: clk_r <= host_byte & `ATX_WM_CLK;
				`ATX_OFS_FMT: fmt_r <= host_byte & `ATX_WM_FMT;
				`ATX_OFS_MASK1: mask1_r <= host_byte & `ATX_WM_IRQ1;
				`ATX_OFS_MODE1H: mode1h_r <= host_byte & `ATX_WM_IRQ1;
				`ATX_OFS_MODE1L: mode1l_r <= host_byte & `ATX_WM_IRQ1;
				`ATX_OFS_MASK2: mask2_r <= host_byte & `ATX_WM_IRQ2;
				`ATX_OFS_MODE2H: mode2h_r <= host_byte & `ATX_WM_IRQ2;
				`ATX_OFS_MODE2L: mode2l_r <= host_byte & `ATX_WM_IRQ2;
				`ATX_OFS_CSBUF: csbuf_r <= host_byte & `ATX_WM_CSBUF;
				`ATX_OFS_UBUF: ubuf_r <= host_byte & `ATX_WM_UBUF;
				default: ctl1_r <= ctl1_r;
			endcase
		end
	end

	// Interrupt sources; a boundary pulse counts as slip only while the pin is an input
	assign blk_pulse = blk_sync & ~blk_d_r & ~ctl1_r[`ATX_C1_BLKDIR];
	assign src1 = {source_slip_event | blk_pulse, 5'h00, status_buffer_transfer_event, 1'b0};
	assign src2 = {5'h00, user_buffer_transfer_event, 2'h0};

	// Per-bit detection gated by the mask
	always @* begin
		ev1 = 8'h00;
		ev2 = 8'h00;
		for (i = 0; i < 8; i = i + 1) begin
			ev1[i] = mask1_r[i] & irq_hit({mode1h_r[i], mode1l_r[i]}, src1[i], src1_d_r[i]);
			ev2[i] = mask2_r[i] & irq_hit({mode2h_r[i], mode2l_r[i]}, src2[i], src2_d_r[i]);
		end
		// A new event in the reading cycle survives the clear; live level sources re-set
		stat1_nxt = ((rd_stat1 ? 8'h00 : stat1_r) | ev1) & mask1_r;
		stat2_nxt = ((rd_stat2 ? 8'h00 : stat2_r) | ev2) & mask2_r;
	end

	// Sticky status and source history; detection keeps running whether run is high or low
	always @(posedge ref_clk) begin
		if (rst) begin
			stat1_r <= `ATX_RST_VAL;
			stat2_r <= `ATX_RST_VAL;
			src1_d_r <= 8'h00;
			src2_d_r <= 8'h00;
			blk_d_r <= 1'b0;
		end else if (ce) begin
			stat1_r <= stat1_nxt;
			stat2_r <= stat2_nxt;
			src1_d_r <= src1;
			src2_d_r <= src2;
			blk_d_r <= blk_sync;
		end
	end

	// Read data selection; unused bits were never stored so they read zero
	always @* begin
		case (ptr_r)
			`ATX_OFS_CTL1: rd_mux = ctl1_r;
			`ATX_OFS_MONO: rd_mux = mono_r;
			`ATX_OFS_FLOW: rd_mux = flow_r;
			`ATX_OFS_CLK: rd_mux = clk_r;
			`ATX_OFS_FMT: rd_mux = fmt_r;
			`ATX_OFS_STAT1: rd_mux = stat1_r & mask1_r;
			`ATX_OFS_STAT2: rd_mux = stat2_r & mask2_r;
			`ATX_OFS_MASK1: rd_mux = mask1_r;
			`ATX_OFS_MODE1H: rd_mux = mode1h_r;
			`ATX_OFS_MODE1L: rd_mux = mode1l_r;
			`ATX_OFS_MASK2: rd_mux = mask2_r;
			`ATX_OFS_MODE2H: rd_mux = mode2h_r;
			`ATX_OFS_MODE2L: rd_mux = mode2l_r;
			`ATX_OFS_CSBUF: rd_mux = csbuf_r;
			`ATX_OFS_UBUF: rd_mux = ubuf_r;
			`ATX_OFS_ID: rd_mux = {ID_CODE, REV_CODE};
			default: rd_mux = 8'h00;
		endcase
	end

	// Two-stage read so buffer and register bytes share one fixed latency
	always @(posedge ref_clk) begin
		if (rst) begin
			rd_reg_r <= 8'h00;
			rd_buf_r <= 1'b0;
			rd_stage_r <= 1'b0;
			host_rd_data <= 8'h00;
			host_rd_valid <= 1'b0;
		end else if (ce) begin
			rd_stage_r <= host_rd & ~host_wr_map;
			rd_reg_r <= rd_mux;
			rd_buf_r <= in_buf;
			host_rd_valid <= rd_stage_r;
			if (rd_stage_r) begin
				host_rd_data <= rd_buf_r ? (run ? buf_q : 8'h00) : rd_reg_r;
			end
		end
	end

	// Interrupt pin drive in the selected style
	always @* begin
		irq_any = (|stat1_r) | (|stat2_r);
	end

	always @(posedge ref_clk) begin
		if (rst) begin
			irq_pin_out <= 1'b0;
			irq_pin_oe <= 1'b1;
		end else if (ce) begin
			case (ctl1_r[`ATX_C1_STY_HI:`ATX_C1_STY_LO])
				`ATX_STY_LOW: begin
					irq_pin_out <= ~irq_any;
					irq_pin_oe <= 1'b1;
				end
				`ATX_STY_OD: begin
					irq_pin_out <= 1'b0;
					irq_pin_oe <= irq_any;
				end
				default: begin
					irq_pin_out <= irq_any;
					irq_pin_oe <= 1'b1;
				end
			endcase
		end
	end

	// Line driver path; bypass passes through the filter, costing a few cycles of delay
	assign line_src = flow_r[`ATX_F_BYPASS] ? rxp_sync : encoded_stream_in;
	assign line_off = flow_r[`ATX_F_DRVOFF] | ~run;

	always @(posedge ref_clk) begin
		if (rst) begin
			line_p_out <= 1'b0;
			line_n_out <= 1'b0;
			block_boundary_pin_out <= 1'b0;
			block_boundary_pin_oe <= 1'b0;
		end else if (ce) begin
			line_p_out <= line_off ? 1'b0 : line_src;
			line_n_out <= line_off ? 1'b0 : ~line_src;
			block_boundary_pin_oe <= ctl1_r[`ATX_C1_BLKDIR];
			block_boundary_pin_out <= ctl1_r[`ATX_C1_BLKDIR] & block_start_in;
		end
	end

	// Serial input port framing from the filtered bit and frame clocks
	always @(posedge ref_clk) begin
		if (rst) begin
			bclk_d_r <= 1'b0;
			sample_strobe <= 1'b0;
			channel_is_left <= 1'b0;
		end else if (ce) begin
			bclk_d_r <= bclk_sync;
			if (fmt_r[`ATX_S_BPOL]) begin
				sample_strobe <= run & ~bclk_sync & bclk_d_r;
			end else begin
				sample_strobe <= run & bclk_sync & ~bclk_d_r;
			end
			channel_is_left <= fclk_sync ^ fmt_r[`ATX_S_FPOL];
		end
	end

	// Ratio and master bit clock rate
	always @* begin
		ratio_val = ratio_of(clk_r[`ATX_K_RAT_HI:`ATX_K_RAT_LO]);
		bclk_val = fmt_r[`ATX_S_BCLK] ? `ATX_BCLK_128 : `ATX_BCLK_64;
	end

	// Audio selection, status source and configuration outputs
	always @(posedge ref_clk) begin
		if (rst) begin
			subframe_audio <= 24'h000000;
			status_from_b <= 1'b0;
			validity_bit <= 1'b0;
			datapath_run <= 1'b0;
			mclk_ratio <= `ATX_RATIO_256;
			master_bclk_div <= 4'h4;
			input_port_master <= 1'b0;
			word_length <= `ATX_RES_24;
			input_right_justified <= 1'b0;
			input_msb_delay <= 1'b0;
			user_bit_mode <= 2'h0;
			status_transfer_inhibit <= 1'b0;
			user_transfer_inhibit <= 1'b0;
			buffer_holds_user <= 1'b0;
		end else if (ce) begin
			if (ctl1_r[`ATX_C1_MUTE]) begin
				subframe_audio <= 24'h000000;
			end else if (mono_r[`ATX_M_ENABLE]) begin
				subframe_audio <= mono_r[`ATX_M_CHAN] ? right_sample : left_sample;
			end else begin
				subframe_audio <= subframe_b ? right_sample : left_sample;
			end
			if (mono_r[`ATX_M_ENABLE] && mono_r[`ATX_M_STATUS]) begin
				status_from_b <= mono_r[`ATX_M_CHAN];
			end else begin
				status_from_b <= subframe_b;
			end
			validity_bit <= ctl1_r[`ATX_C1_VALID];
			datapath_run <= run;
			mclk_ratio <= ratio_val;
			master_bclk_div <= ratio_val[9:6] / bclk_val[9:6];
			input_port_master <= fmt_r[`ATX_S_MASTER];
			case (fmt_r[`ATX_S_RES_HI:`ATX_S_RES_LO])
				2'h1: word_length <= `ATX_RES_20;
				2'h2: word_length <= `ATX_RES_16;
				default: word_length <= `ATX_RES_24;
			endcase
			input_right_justified <= fmt_r[`ATX_S_JUST];
			input_msb_delay <= ~fmt_r[`ATX_S_JUST] & fmt_r[`ATX_S_DEL];
			user_bit_mode <= ubuf_r[3:2];
			status_transfer_inhibit <= csbuf_r[2];
			user_transfer_inhibit <= ubuf_r[0];
			buffer_holds_user <= csbuf_r[5];
		end
	end

endmodule // atx_ctrl_regs
`default_nettype wire

// >>> logic/atx_pin_sync.v
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
`default_nettype none

module atx_pin_sync #(
	parameter WIDTH = 4
) (
	input wire ref_clk,
	input wire rst,
	input wire ce,
	input wire [WIDTH-1:0] pin_in,
	output reg [WIDTH-1:0] pin_stable
);

	reg [WIDTH-1:0] s1_r;
	reg [WIDTH-1:0] s2_r;
	reg [WIDTH-1:0] s3_r;

	// First stage feeds only the second; the result moves only when stages two and three agree
	always @(posedge ref_clk) begin
		if (rst) begin
			s1_r <= {WIDTH{1'b0}};
			s2_r <= {WIDTH{1'b0}};
			s3_r <= {WIDTH{1'b0}};
			pin_stable <= {WIDTH{1'b0}};
		end else if (ce) begin
			s1_r <= pin_in;
			s2_r <= s1_r;
			s3_r <= s2_r;
			pin_stable <= (s2_r & s3_r) | (pin_stable & (s2_r ^ s3_r));
		end
	end

endmodule // atx_pin_sync
`default_nettype wire

// >>> logic/atx_side_buf.v
// Small side-data buffer memory with registered read data
`timescale 1ns/100ps
`default_nettype none

module atx_side_buf #(
	parameter DEPTH = 24,
	parameter AW = 5
) (
	input wire ref_clk,
	input wire rst,
	input wire ce,
	input wire wr_en,
	input wire [AW-1:0] addr,
	input wire [7:0] wr_data,
	output reg [7:0] rd_data
);

	reg [7:0] mem_r [0:DEPTH-1];

	// Contents are not reset; only the read register has a defined start value
	always @(posedge ref_clk) begin
		if (ce && wr_en) begin
			mem_r[addr] <= wr_data;
		end
	end

	// Read data always comes out of a flop, one cycle after the address
	always @(posedge ref_clk) begin
		if (rst) begin
			rd_data <= 8'h00;
		end else if (ce) begin
			rd_data <= mem_r[addr];
		end
	end

endmodule // atx_side_buf
`default_nettype wire

// >>> test/atx_ctrl_regs_properties.sv
// Port checks for the transmitter control bank
`timescale 1ns/100ps
`default_nettype none
module atx_ctrl_regs_chk #(
	parameter BUF_DEPTH = 24
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic host_rd,
	input wire logic host_wr_map,
	input wire logic host_rd_valid,
	input wire logic irq_pin_oe,
	input wire logic line_p_out,
	input wire logic line_n_out,
	input wire logic sample_strobe,
	input wire logic datapath_run,
	input wire logic [9:0] mclk_ratio,
	input wire logic [3:0] master_bclk_div,
	input wire logic [4:0] word_length,
	input wire logic input_right_justified,
	input wire logic input_msb_delay
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	// Read answer slot is fixed so the host can count cycles
	// A pointer strobe in the same cycle wins, and a frozen cycle delays the answer
	AST_RD_ANSWER: assert property (host_rd && ce && !host_wr_map ##1 ce |->
		##1 host_rd_valid)
		else $error("read not answered");
	AST_RD_CAUSE: assert property (host_rd_valid |-> $past(host_rd, 2))
		else $error("answer without read");
	// Both line outputs high would short the cable pair
	AST_LINE_DIFF: assert property (!(line_p_out && line_n_out))
		else $error("line outputs both high");
	AST_LINE_STOP: assert property (!datapath_run [*3] |-> !line_p_out && !line_n_out)
		else $error("line active while stopped");
	AST_RATIO: assert property (mclk_ratio inside {10'h100, 10'h180, 10'h200})
		else $error("bad clock ratio");
	AST_WLEN: assert property (word_length inside {5'h18, 5'h14, 5'h10})
		else $error("bad word length");
	AST_BCLK: assert property (({1'b0, master_bclk_div, 6'h00} == {1'b0, mclk_ratio}) ||
		({master_bclk_div, 7'h00} == {1'b0, mclk_ratio}))
		else $error("bad bit clock divider");
	AST_STROBE_RUN: assert property (sample_strobe |-> datapath_run || $past(datapath_run))
		else $error("strobe while stopped");
	AST_DELAY_LJ: assert property (input_msb_delay |-> !input_right_justified)
		else $error("delay with right justify");
	AST_RESET_IDLE: assert property ($fell(rst) |-> !host_rd_valid && irq_pin_oe && !line_p_out)
		else $error("bad state after reset");
endmodule // atx_ctrl_regs_chk
bind atx_ctrl_regs atx_ctrl_regs_chk #(.BUF_DEPTH(BUF_DEPTH)) atx_ctrl_regs_chk_i (
	.ref_clk(ref_clk), .rst(rst), .ce(ce), .host_rd(host_rd), .host_rd_valid(host_rd_valid),
	.irq_pin_oe(irq_pin_oe), .line_p_out(line_p_out), .line_n_out(line_n_out),
	.sample_strobe(sample_strobe), .datapath_run(datapath_run), .mclk_ratio(mclk_ratio),
	.master_bclk_div(master_bclk_div), .word_length(word_length), .host_wr_map(host_wr_map),
	.input_right_justified(input_right_justified), .input_msb_delay(input_msb_delay));
`default_nettype wire

// >>> test/atx_ctrl_regs_test.sv
// Self-checking bench for the transmitter control bank
`timescale 1ns/100ps
`default_nettype none
`include "atx_ctrl_map.vh"
module atx_ctrl_regs_test;
	localparam logic [3:0] IDC = 4'h5; // Arbitrary identity value
	localparam logic [3:0] REVC = 4'h2; // Arbitrary revision value
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic ev_slip = 0, ev_cs = 0, ev_u = 0, blk_in = 0, blk_start = 0, rx_pin = 0, enc = 0;
	logic bclk = 0, fclk = 0, sub_b = 0;
	logic [23:0] lsamp = 24'h0, rsamp = 24'h0;
	wire wr_map, wr_dat, rd_s, rd_valid, irq_out, irq_oe, blk_out, blk_oe, lp, ln, strobe;
	wire is_left, st_b, vbit, run, pmaster, rj, dly;
	wire [7:0] hbyte, rd_data;
	wire [23:0] audio;
	wire [9:0] ratio;
	wire [3:0] bdiv;
	wire [4:0] wlen, bufc;
	wire irq_wire = irq_oe ? irq_out : 1'b1; // Pull-up when released
	int n_fail = 0;
	int tests_run = 0;
	int rat [4] = '{256, 384, 512, 256};
	int wl [4] = '{24, 20, 16, 24};
	logic [7:0] shadow [0:127];
	logic [7:0] rd;
	always #20 ref_clk = ~ref_clk;
	always #160 bclk = ~bclk;
	atx_host_model atx_host_model_i (.ref_clk(ref_clk), .host_rd_data(rd_data),
		.host_rd_valid(rd_valid), .host_wr_map(wr_map), .host_wr_data(wr_dat),
		.host_rd(rd_s), .host_byte(hbyte));
	atx_ctrl_regs #(.ID_CODE(IDC), .REV_CODE(REVC)) atx_ctrl_regs_i (
		.ref_clk(ref_clk), .rst(rst), .ce(1'b1), .host_wr_map(wr_map), .host_wr_data(wr_dat),
		.host_rd(rd_s), .host_byte(hbyte), .host_rd_data(rd_data), .host_rd_valid(rd_valid),
		.source_slip_event(ev_slip), .status_buffer_transfer_event(ev_cs),
		.user_buffer_transfer_event(ev_u), .irq_pin_out(irq_out), .irq_pin_oe(irq_oe),
		.block_boundary_pin_in(blk_in), .block_boundary_pin_out(blk_out),
		.block_boundary_pin_oe(blk_oe), .block_start_in(blk_start), .receive_input_pin(rx_pin),
		.encoded_stream_in(enc), .line_p_out(lp), .line_n_out(ln), .input_bit_clock(bclk),
		.input_frame_clock(fclk), .sample_strobe(strobe), .channel_is_left(is_left),
		.left_sample(lsamp), .right_sample(rsamp), .subframe_b(sub_b), .subframe_audio(audio),
		.status_from_b(st_b), .validity_bit(vbit), .datapath_run(run), .mclk_ratio(ratio),
		.master_bclk_div(bdiv), .input_port_master(pmaster), .word_length(wlen),
		.input_right_justified(rj), .input_msb_delay(dly), .user_bit_mode(bufc[4:3]),
		.status_transfer_inhibit(bufc[2]), .user_transfer_inhibit(bufc[1]),
		.buffer_holds_user(bufc[0]));
	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value at %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	// Writable bits per address up to 0x0e; the bench keeps its own register image
	function automatic logic [7:0] wmask(input int a);
		case (a)
			1: return `ATX_WM_CTL1;
			2: return `ATX_WM_MONO;
			3: return `ATX_WM_FLOW;
			4: return `ATX_WM_CLK;
			5: return `ATX_WM_FMT;
			9, 10, 11: return `ATX_WM_IRQ1;
			12, 13, 14: return `ATX_WM_IRQ2;
			default: return 8'h00;
		endcase
	endfunction
	task automatic settle(input int n);
		repeat (n) @(posedge ref_clk);
		@(negedge ref_clk);
	endtask
	task automatic wreg(input logic [6:0] a, input logic [7:0] d);
		atx_host_model_i.wr(a, d);
		shadow[a] = d & wmask(a);
	endtask
	// A lost answer ends the run at once
	task automatic got_chk(input logic [7:0] e);
		atx_host_model_i.get(rd);
		if (atx_host_model_i.n_timeout != 0) begin
			n_fail++;
			final_report();
		end
		chk({16'h0, rd}, {16'h0, e});
	endtask
	task automatic rreg(input logic [6:0] a, input logic [7:0] e);
		atx_host_model_i.ptr({1'b0, a});
		got_chk(e);
	endtask
	task automatic slip();
		@(posedge ref_clk);
		ev_slip <= 1'b1;
		@(posedge ref_clk);
		ev_slip <= 1'b0;
		settle(3);
	endtask
	// Strobes over 64 cycles, which span eight bit clock periods
	task automatic strobes(output int n);
		n = 0;
		repeat (64) begin
			@(negedge ref_clk);
			if (strobe === 1'b1) n++;
		end
	endtask
	initial begin
		int i, n;
		logic [7:0] d;
		void'($urandom(39));
		repeat (20) @(posedge ref_clk);
		rst <= 1'b0;
		for (i = 0; i < 20; i++) rreg(7'(i), 8'h00);
		rreg(7'h40, 8'h00);
		rreg(7'h7f, {IDC, REVC});
		chk(ratio, 256);
		chk(wlen, 24);
		$display("test reset done");
		atx_host_model_i.ptr(8'h81);
		for (i = 1; i <= 5; i++) begin
			d = $urandom;
			atx_host_model_i.dat(d);
			shadow[i] = d & wmask(i);
		end
		atx_host_model_i.ptr(8'h81);
		for (i = 1; i <= 5; i++) got_chk(shadow[i]);
		rreg(7'h05, shadow[5]);
		got_chk(shadow[5]);
		$display("test pointer done");
		for (i = 0; i < 4; i++) begin
			wreg(4, 8'h00);
			wreg(4, {2'b01, 2'(i), 4'h0});
			wreg(5, {1'b1, i[0], 2'(i), 4'h8});
			settle(2);
			chk(ratio, rat[i]);
			chk(wlen, wl[i]);
			chk(bdiv, rat[i] / (64 << i[0]));
			chk({pmaster, rj, dly}, 3'b110);
		end
		wreg(5, 8'h04);
		settle(2);
		chk({rj, dly}, 2'b01);
		strobes(n);
		chk(n >= 7 && n <= 9, 1);
		wreg(5, 8'h02);
		strobes(n);
		chk(n >= 7 && n <= 9, 1);
		fclk <= 1'b1;
		wreg(5, 8'h00);
		settle(8);
		chk(is_left, 1);
		wreg(5, 8'h01);
		settle(8);
		chk(is_left, 0);
		$display("test format done");
		wreg(3, 8'h00);
		for (i = 0; i < 4; i++) begin
			enc <= $urandom;
			settle(3);
			chk({lp, ln}, {enc, ~enc});
		end
		wreg(3, 8'h40);
		settle(3);
		chk({lp, ln}, 2'b00);
		wreg(3, 8'h20);
		for (i = 0; i < 4; i++) begin
			rx_pin <= $urandom;
			settle(8);
			chk(lp, rx_pin);
		end
		wreg(4, 8'h00);
		settle(3);
		chk({lp, ln}, 2'b00);
		strobes(n);
		chk(n, 0);
		// Buffer byte written while running must survive a refused write while stopped
		wreg(4, 8'h40);
		wreg(7'h20, 8'ha5);
		wreg(4, 8'h00);
		wreg(7'h20, 8'h5a);
		rreg(7'h20, 8'h00);
		wreg(4, 8'h40);
		rreg(7'h20, 8'ha5);
		wreg(18, 8'hff);
		wreg(19, 8'hff);
		rreg(18, `ATX_WM_CSBUF);
		rreg(19, `ATX_WM_UBUF);
		chk(bufc, 5'h1f);
		$display("test line done");
		lsamp <= $urandom;
		rsamp <= $urandom;
		sub_b <= 1'b1;
		wreg(1, 8'h00);
		wreg(2, 8'h00);
		settle(3);
		chk({audio, st_b}, {rsamp, 1'b1});
		wreg(2, 8'h06);
		settle(3);
		chk({audio, st_b}, {lsamp, 1'b0});
		wreg(2, 8'h07);
		settle(3);
		chk({audio, st_b}, {rsamp, 1'b1});
		wreg(1, 8'h50);
		settle(3);
		chk({audio, vbit}, {24'h0, 1'b1});
		blk_start <= 1'b1;
		wreg(1, 8'h01);
		settle(3);
		chk({vbit, blk_oe, blk_out}, 3'b011);
		$display("test datapath done");
		wreg(1, 8'h00);
		wreg(9, 8'h82);
		slip();
		chk(irq_wire, 1);
		rreg(7, 8'h80);
		settle(3);
		chk({blk_oe, irq_wire}, 2'b00);
		rreg(7, 8'h00);
		wreg(1, 8'h02);
		settle(2);
		chk(irq_wire, 1);
		slip();
		chk(irq_wire, 0);
		rreg(7, 8'h80);
		wreg(1, 8'h04);
		settle(2);
		chk(irq_oe, 0);
		slip();
		chk(irq_wire, 0);
		rreg(7, 8'h80);
		wreg(10, 8'h02);
		ev_cs <= 1'b1;
		settle(3);
		rreg(7, 8'h02);
		got_chk(8'h02);
		ev_cs <= 1'b0;
		settle(3);
		got_chk(8'h02);
		got_chk(8'h00);
		wreg(11, 8'h80);
		ev_slip <= 1'b1;
		settle(3);
		rreg(7, 8'h00);
		ev_slip <= 1'b0;
		settle(3);
		rreg(7, 8'h80);
		wreg(11, 8'h00);
		wreg(9, 8'h00);
		slip();
		rreg(7, 8'h00);
		wreg(12, 8'h04);
		ev_u <= 1'b1;
		settle(3);
		ev_u <= 1'b0;
		rreg(8, 8'h04);
		wreg(9, 8'h80);
		blk_in <= 1'b1;
		settle(8);
		blk_in <= 1'b0;
		settle(6);
		rreg(7, 8'h80);
		$display("test interrupt done");
		final_report();
	end
endmodule // atx_ctrl_regs_test
`default_nettype wire

// >>> test/atx_host_model.sv
// Host microcontroller stand-in on the byte-level control port
`timescale 1ns/100ps
`default_nettype none
module atx_host_model (
	input wire logic ref_clk,
	input wire logic [7:0] host_rd_data,
	input wire logic host_rd_valid,
	output logic host_wr_map = 1'b0,
	output logic host_wr_data = 1'b0,
	output logic host_rd = 1'b0,
	output logic [7:0] host_byte = 8'h00
);
	int n_timeout = 0;
	// Data lines carry the inverse after a strobe so stale bytes never pass
	task automatic ptr(input logic [7:0] p);
		@(posedge ref_clk);
		host_wr_map <= 1'b1;
		host_byte <= p;
		@(posedge ref_clk);
		host_wr_map <= 1'b0;
		host_byte <= ~p;
	endtask
	task automatic dat(input logic [7:0] d);
		@(posedge ref_clk);
		host_wr_data <= 1'b1;
		host_byte <= d;
		@(posedge ref_clk);
		host_wr_data <= 1'b0;
		host_byte <= ~d;
	endtask
	// Reserved places 0x0f to 0x11, 0x1e and 0x1f may hold test modes, so they are never written
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		if (!(a inside {[7'h0f:7'h11], 7'h1e, 7'h1f})) begin
			ptr({1'b0, a});
			dat(d);
		end
	endtask
	// Read strobe, then a bounded wait for the answer
	task automatic get(output logic [7:0] d);
		int i;
		@(posedge ref_clk);
		host_rd <= 1'b1;
		@(posedge ref_clk);
		host_rd <= 1'b0;
		for (i = 0; i < 6 && host_rd_valid !== 1'b1; i++) @(negedge ref_clk);
		if (host_rd_valid !== 1'b1) n_timeout++;
		d = host_rd_data;
	endtask
endmodule // atx_host_model
`default_nettype wire
